/* hw/amcid_top.sv */
// Match-count target, input diagnostics and interrupts behind APB
//
// Summary of operation
// - Flag raised after target consecutive matches
// - Target zero: flag on first match
// - Target writes ignored while conversion runs
// - Diag bit 1 enables high-side source
// - Diag bit 0 enables low-side source
// - Diag bit 6 shows live supply fault
// - Diag bits 5:2 show live input faults
// - Flags meaningful only with one source enabled
// - Miss decrements or clears the counter
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
module amcid_top (
  input wire logic pclk,                 // System clock, 25 MHz
  input wire logic presetn,              // Async reset, active low
  input wire logic psel,                 // APB select
  input wire logic penable,              // APB enable
  input wire logic pwrite,               // APB direction, 1 = write
  input wire logic [9:0] paddr,          // APB byte address
  input wire logic [31:0] pwdata,        // APB write data
  input wire logic [3:0] pstrb,          // APB byte strobes
  output logic [31:0] prdata,            // APB read data
  output logic pready,                   // APB ready
  output logic pslverr,                  // APB error, unmapped address
  input wire logic conv_running,         // ADC conversion in progress
  input wire logic result_valid,         // One pulse per finished conversion
  input wire logic result_true,          // Comparison outcome of that result
  input wire logic [4:0] fault_pins,     // Raw faults: supply, inputs 4..1
  output logic high_side_source_en,      // High-side diagnostic source on
  output logic low_side_source_en,       // Low-side diagnostic source on
  output logic compare_event_flag,       // Pulse on each comparator event
  output logic irq                       // Level interrupt
);

  // ==========================================================
  // Address decode
  logic [7:0] acc_idx;
  logic setup_phase;
  logic wr_access;
  logic hit_diag;
  logic hit_target;
  logic hit_config;
  logic hit_status;
  logic hit_clear;
  logic hit_enable;
  logic addr_known;
  logic lane0;

  assign acc_idx = paddr[9:2];
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign lane0 = pstrb[0];
  assign hit_diag = (acc_idx == amcid_pkg::IDX_DIAG);
  assign hit_target = (acc_idx == amcid_pkg::IDX_TARGET);
  assign hit_config = (acc_idx == amcid_pkg::IDX_CONFIG);
  assign hit_status = (acc_idx == amcid_pkg::IDX_IRQ_STATUS);
  assign hit_clear = (acc_idx == amcid_pkg::IDX_IRQ_CLEAR);
  assign hit_enable = (acc_idx == amcid_pkg::IDX_IRQ_ENABLE);
  assign addr_known = (paddr[1:0] == 2'h0) &&
                      (hit_diag || hit_target || hit_config ||
                       hit_status || hit_clear || hit_enable);

  // ==========================================================
  // Fault pin synchronisers
  logic [4:0] fault_meta;
  logic [4:0] fault_sync;
  logic [4:0] fault_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_meta <= 5'h00;
      fault_sync <= 5'h00;
    end else begin
      fault_meta <= fault_pins;
      fault_sync <= fault_meta;
    end
  end

  // ==========================================================
  // Diagnostic source enables
  logic [1:0] next_src_en;

  always_comb begin
    next_src_en = {high_side_source_en, low_side_source_en};
    if (wr_access && hit_diag && lane0) begin
      next_src_en[amcid_pkg::DIAG_HIGH_BIT] = pwdata[amcid_pkg::DIAG_HIGH_BIT];
      next_src_en[amcid_pkg::DIAG_LOW_BIT] = pwdata[amcid_pkg::DIAG_LOW_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_side_source_en <= amcid_pkg::DIAG_EN_RESET[amcid_pkg::DIAG_HIGH_BIT];
      low_side_source_en <= amcid_pkg::DIAG_EN_RESET[amcid_pkg::DIAG_LOW_BIT];
    end else begin
      high_side_source_en <= next_src_en[amcid_pkg::DIAG_HIGH_BIT];
      low_side_source_en <= next_src_en[amcid_pkg::DIAG_LOW_BIT];
    end
  end

  // Flags mean nothing with both sources off, so they read as zero then
  logic diag_active;
  logic [4:0] fault_live;

  assign diag_active = high_side_source_en || low_side_source_en;
  assign fault_live = diag_active ? fault_sync : 5'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_prev <= 5'h00;
    end else begin
      fault_prev <= fault_live;
    end
  end

  // ==========================================================
  // Match counter configuration
  logic [7:0] target;
  logic dec_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target <= amcid_pkg::TARGET_RESET;
    end else if (wr_access && hit_target && lane0 && !conv_running) begin
      target <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_mode <= amcid_pkg::CONFIG_DEC_RESET;
    end else if (wr_access && hit_config && lane0) begin
      dec_mode <= pwdata[amcid_pkg::CONFIG_DEC_BIT];
    end
  end

  amcid_cnt_if cnt_link ();

  assign cnt_link.result_valid = result_valid;
  assign cnt_link.result_true = result_true;
  assign cnt_link.dec_mode = dec_mode;
  assign cnt_link.target = target;

  amcid_match_counter u_counter (
    .pclk(pclk),
    .presetn(presetn),
    .bus(cnt_link.cnt)
  );

  assign compare_event_flag = cnt_link.hit;

  // ==========================================================
  // Interrupt status, enable and clear
  logic [1:0] irq_status;
  logic [1:0] irq_enable;
  logic [1:0] irq_events;
  logic [1:0] irq_clear;

  assign irq_events[amcid_pkg::IRQ_MATCH_BIT] = cnt_link.hit;
  assign irq_events[amcid_pkg::IRQ_FAULT_BIT] = |(fault_live & ~fault_prev);
  assign irq_clear = (wr_access && hit_clear && lane0) ? pwdata[1:0] : 2'h0;

  // A new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= amcid_pkg::IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= amcid_pkg::IRQ_RESET;
    end else if (wr_access && hit_enable && lane0) begin
      irq_enable <= pwdata[1:0];
    end
  end

  assign irq = |(irq_status & irq_enable);

  // ==========================================================
  // Read path, captured in the setup cycle so prdata comes from flops
  logic [7:0] diag_view;
  logic [7:0] rd_byte;
  logic [7:0] rd_count;
  logic bad_addr;

  always_comb begin
    diag_view = 8'h00;
    diag_view[amcid_pkg::DIAG_SUPPLY_BIT] = fault_live[4];
    diag_view[amcid_pkg::DIAG_INPUT_MSB:amcid_pkg::DIAG_INPUT_LSB] = fault_live[3:0];
    diag_view[amcid_pkg::DIAG_HIGH_BIT] = high_side_source_en;
    diag_view[amcid_pkg::DIAG_LOW_BIT] = low_side_source_en;
  end

  always_comb begin
    rd_byte = 8'h00;
    rd_count = 8'h00;
    if (hit_diag) begin
      rd_byte = diag_view;
    end else if (hit_target) begin
      rd_byte = target;
    end else if (hit_config) begin
      rd_byte = {7'h00, dec_mode};
      rd_count = cnt_link.count;
    end else if (hit_status) begin
      rd_byte = {6'h00, irq_status};
    end else if (hit_enable) begin
      rd_byte = {6'h00, irq_enable};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      bad_addr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= {16'h0000, rd_count, rd_byte};
      bad_addr <= !addr_known;
    end
  end

  // Zero wait states; unmapped addresses end with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && bad_addr;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_match_bypass: assert property (
    result_valid && result_true && target == 8'h00 |=> compare_event_flag
  ) else $error("first match with zero target did not flag");

  a_match_cause: assert property (
    compare_event_flag |-> $past(result_valid) && $past(result_true)
  ) else $error("event flag without a true comparison");

  a_match_reach: assert property (
    result_valid && result_true && target != 8'h00 &&
    cnt_link.count == target - 8'h01 |=> compare_event_flag
  ) else $error("target reached but no event flag");

  a_match_early: assert property (
    result_valid && result_true && target > 8'h01 &&
    cnt_link.count + 8'h02 <= target |=> !compare_event_flag
  ) else $error("event flag before target reached");

  a_miss_clear: assert property (
    result_valid && !result_true && !dec_mode |=> cnt_link.count == 8'h00
  ) else $error("miss did not clear counter");

  a_miss_decrement: assert property (
    result_valid && !result_true && dec_mode && cnt_link.count != 8'h00
    |=> cnt_link.count == $past(cnt_link.count) - 8'h01
  ) else $error("miss did not decrement counter");

  a_target_locked: assert property (
    conv_running && wr_access && hit_target |=> $stable(target)
  ) else $error("target changed during conversion");

  a_target_written: assert property (
    !conv_running && wr_access && hit_target && lane0
    |=> target == $past(pwdata[7:0])
  ) else $error("idle target write lost");

  a_high_enable: assert property (
    wr_access && hit_diag && lane0
    |=> high_side_source_en == $past(pwdata[1])
  ) else $error("high-side enable not written");

  a_low_enable: assert property (
    wr_access && hit_diag && lane0
    |=> low_side_source_en == $past(pwdata[0])
  ) else $error("low-side enable not written");

  a_supply_live: assert property (
    setup_phase && hit_diag && diag_active
    |=> prdata[6] == $past(fault_sync[4])
  ) else $error("supply fault flag not live");

  a_input_live: assert property (
    setup_phase && hit_diag && diag_active
    |=> prdata[5:2] == $past(fault_sync[3:0])
  ) else $error("input fault flags not live");

  a_diag_off_zero: assert property (
    setup_phase && hit_diag && !diag_active |=> prdata[6:2] == 5'h00
  ) else $error("fault flags shown with diagnosis off");

  a_unused_zero: assert property (
    setup_phase && hit_diag |=> prdata[7] == 1'b0
  ) else $error("unused diagnostic bit not zero");

  a_event_status: assert property (
    compare_event_flag |=> irq_status[0] ##0 (irq_enable[0] -> irq)
  ) else $error("event did not reach status and interrupt");

  a_fault_status: assert property (
    irq_events[amcid_pkg::IRQ_FAULT_BIT] |=> irq_status[amcid_pkg::IRQ_FAULT_BIT]
  ) else $error("fault edge did not reach status");

  a_count_hold: assert property (
    !result_valid |=> $stable(cnt_link.count)
  ) else $error("counter moved without a result");

  a_count_step: assert property (
    result_valid && result_true && target != 8'h00 && cnt_link.count + 8'h01 < target
    |=> cnt_link.count == $past(cnt_link.count) + 8'h01
  ) else $error("true comparison did not increment counter");

  a_hit_clears: assert property (
    compare_event_flag |-> cnt_link.count == 8'h00
  ) else $error("counter not restarted after event");

  a_miss_floor: assert property (
    result_valid && !result_true && dec_mode && cnt_link.count == 8'h00
    |=> cnt_link.count == 8'h00
  ) else $error("decrement went below zero");

  a_source_hold: assert property (
    !(wr_access && hit_diag && lane0)
    |=> $stable(high_side_source_en) && $stable(low_side_source_en)
  ) else $error("source enable changed without a write");

  c_bypass_event: cover property (
    target == 8'h00 && result_valid && result_true ##1 compare_event_flag
  );

  c_counted_event: cover property (
    target == 8'h03 && result_valid && result_true ##1 compare_event_flag
  );

  c_locked_write: cover property (conv_running && wr_access && hit_target);

  c_fault_irq: cover property (irq_events[1] ##1 irq);

  c_decrement_miss: cover property (result_valid && !result_true && dec_mode && cnt_link.count != 8'h00);

endmodule : amcid_top

/* hw/amcid_pkg.sv */
// Constants for the match-count target and input diagnostic block
package amcid_pkg;

  // ==========================================================
  // Bus geometry
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DIAG = 8'h16;
  localparam logic [7:0] IDX_TARGET = 8'h18;
  localparam logic [7:0] IDX_CONFIG = 8'h19;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h1A;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h1B;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h1C;

  // ==========================================================
  // Diagnostic register fields
  localparam int unsigned DIAG_LOW_BIT = 0;
  localparam int unsigned DIAG_HIGH_BIT = 1;
  localparam int unsigned DIAG_INPUT_LSB = 2;
  localparam int unsigned DIAG_INPUT_MSB = 5;
  localparam int unsigned DIAG_SUPPLY_BIT = 6;
  localparam int unsigned DIAG_UNUSED_BIT = 7;
  localparam int unsigned FAULT_W = 5;
  localparam logic [1:0] DIAG_EN_RESET = 2'h0;

  // ==========================================================
  // Match counter configuration
  localparam logic [7:0] TARGET_RESET = 8'h00;
  localparam logic [7:0] TARGET_BYPASS = 8'h00;
  localparam int unsigned CONFIG_DEC_BIT = 0;
  localparam int unsigned CONFIG_COUNT_LSB = 8;
  localparam logic CONFIG_DEC_RESET = 1'b0;

  // ==========================================================
  // Interrupt status layout
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_MATCH_BIT = 0;
  localparam int unsigned IRQ_FAULT_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

endpackage : amcid_pkg

/* hw/amcid_cnt_if.sv */
// Link between the register logic and the match counter
`timescale 1ns/1ns
interface amcid_cnt_if;
  logic result_valid;
  logic result_true;
  logic dec_mode;
  logic [7:0] target;
  logic [7:0] count;
  logic hit;

  modport ctl (
    output result_valid, result_true, dec_mode, target,
    input count, hit
  );
  modport cnt (
    input result_valid, result_true, dec_mode, target,
    output count, hit
  );
endinterface : amcid_cnt_if

/* hw/amcid_match_counter.sv */
// Consecutive-match counter behind the comparator event flag
`timescale 1ns/1ns
module amcid_match_counter (
  input wire logic pclk,       // System clock
  input wire logic presetn,    // Async reset, active low
  amcid_cnt_if.cnt bus         // Results in, count and hit out
);

  logic [7:0] next_count;
  logic next_hit;

  // ==========================================================
  // Counting
  always_comb begin
    next_count = bus.count;
    next_hit = 1'b0;
    if (bus.result_valid) begin
      if (bus.result_true) begin
        if (bus.target == amcid_pkg::TARGET_BYPASS) begin
          next_hit = 1'b1;
          next_count = 8'h00;
        end else if (bus.count >= bus.target - 8'h01) begin
          next_hit = 1'b1;
          next_count = 8'h00;
        end else begin
          next_count = bus.count + 8'h01;
        end
      end else if (bus.dec_mode) begin
        if (bus.count != 8'h00) begin
          next_count = bus.count - 8'h01;
        end
      end else begin
        next_count = 8'h00;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus.count <= 8'h00;
      bus.hit <= 1'b0;
    end else begin
      bus.count <= next_count;
      bus.hit <= next_hit;
    end
  end

endmodule : amcid_match_counter

/* sim/amcid_sensor_model.sv */
// Behavioural model of the resistive sensors on the analog inputs and supply pin
`timescale 1ns/1ns
module amcid_sensor_model (
  input wire logic pclk,          // System clock
  input wire logic high_on,       // High-side source enabled
  input wire logic low_on,        // Low-side source enabled
  input wire logic [4:0] cond,    // Fault condition per pin: supply, inputs 4..1
  output logic [4:0] fault_pins   // Raw comparator outputs towards the block
);
  // ==========================================================
  // Pin comparators
  logic [4:0] float_level = 5'h00;

  // Without exactly one source the pins float, so show a changing level
  always @(posedge pclk) begin
    float_level <= ~float_level;
  end

  always_comb begin
    if (high_on ^ low_on) begin
      fault_pins = cond;
    end else begin
      fault_pins = float_level;
    end
  end
endmodule : amcid_sensor_model

/* sim/adc_match_count_input_diag_test.sv */
// Self-checking bench for the match counter and input diagnostics
`timescale 1ns/1ns
module adc_match_count_input_diag_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic conv_running = 1'b0;
  logic result_valid = 1'b0;
  logic result_true = 1'b0;
  logic [4:0] fault_cond = 5'h00;
  wire logic [4:0] fault_pins;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic high_side_source_en;
  logic low_side_source_en;
  logic compare_event_flag;
  logic irq;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int flags = 0;
  integer seed = 30280;
  logic [31:0] rd;
  logic err;
  logic [1:0] en;
  int t;
  int k;
  int mode;

  always #20 pclk = ~pclk;

  amcid_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_running(conv_running),
    .result_valid(result_valid), .result_true(result_true), .fault_pins(fault_pins),
    .high_side_source_en(high_side_source_en), .low_side_source_en(low_side_source_en),
    .compare_event_flag(compare_event_flag), .irq(irq));

  amcid_sensor_model sensors (.pclk(pclk), .high_on(high_side_source_en),
    .low_on(low_side_source_en), .cond(fault_cond), .fault_pins(fault_pins));

  // ==========================================================
  // Helpers
  always @(posedge pclk) begin
    if (compare_event_flag === 1'b1) begin
      flags++;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
    check(32'(n), 32'h00000000);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulse(input logic tr);
    @(posedge pclk);
    result_valid <= 1'b1;
    result_true <= tr;
    @(posedge pclk);
    result_valid <= 1'b0;
  endtask : pulse

  function automatic logic [31:0] exp_diag(input logic [1:0] e, input logic [4:0] c);
    // Flags are masked while diagnosis is off
    return (e == 2'h0) ? 32'h00000000 : {24'h000000, 1'b0, c, e};
  endfunction : exp_diag

  task automatic conclude();
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  always @(posedge pclk) begin
    cycles++;
    if (cycles >= 20000) begin
      fail_count++;
      conclude();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, amcid_pkg::IDX_DIAG, 32'h0);
    check(rd, 32'h00000000);
    check({31'h0, err}, 32'h00000000);
    apb(1'b0, amcid_pkg::IDX_TARGET, 32'h0);
    check(rd, {24'h000000, amcid_pkg::TARGET_RESET});
    apb(1'b0, amcid_pkg::IDX_CONFIG, 32'h0);
    check(rd, 32'h00000000);
    apb(1'b0, 8'h3F, 32'h0);
    check({31'h0, err}, 32'h00000001);
    check(rd, 32'h00000000);
    for (int i = 0; i < 6; i++) begin
      en = 2'h1 + 2'(i & 1);
      fault_cond <= 5'($random(seed));
      apb(1'b1, amcid_pkg::IDX_DIAG, {24'h000000, 6'h3F, en});
      repeat (4) @(posedge pclk);
      check({30'h0, high_side_source_en, low_side_source_en}, {30'h0, en});
      apb(1'b0, amcid_pkg::IDX_DIAG, 32'h0);
      check(rd, exp_diag(en, fault_cond));
    end
    pstrb <= 4'h0;
    apb(1'b1, amcid_pkg::IDX_DIAG, 32'h00000003);
    pstrb <= 4'hF;
    apb(1'b0, amcid_pkg::IDX_DIAG, 32'h0);
    check(rd, exp_diag(en, fault_cond));
    // Rising fault flag reaches status and interrupt
    fault_cond <= 5'h00;
    repeat (4) @(posedge pclk);
    apb(1'b1, amcid_pkg::IDX_IRQ_CLEAR, 32'h00000003);
    apb(1'b1, amcid_pkg::IDX_IRQ_ENABLE, 32'h00000002);
    fault_cond <= 5'h08;
    repeat (4) @(posedge pclk);
    check({31'h0, irq}, 32'h00000001);
    apb(1'b0, amcid_pkg::IDX_IRQ_STATUS, 32'h0);
    check(rd, 32'h00000002);
    // Sources off before any conversion or sleep
    apb(1'b1, amcid_pkg::IDX_DIAG, 32'h0);
    repeat (4) @(posedge pclk);
    apb(1'b0, amcid_pkg::IDX_DIAG, 32'h0);
    check(rd, 32'h00000000);
    apb(1'b1, amcid_pkg::IDX_IRQ_CLEAR, 32'h00000003);
    apb(1'b0, amcid_pkg::IDX_IRQ_STATUS, 32'h0);
    check(rd, 32'h00000000);
    conv_running <= 1'b1;
    apb(1'b1, amcid_pkg::IDX_TARGET, 32'h00000007);
    conv_running <= 1'b0;
    apb(1'b0, amcid_pkg::IDX_TARGET, 32'h0);
    check(rd, 32'h00000000);
    apb(1'b1, amcid_pkg::IDX_IRQ_ENABLE, 32'h00000001);
    pulse(1'b1);
    repeat (2) @(posedge pclk);
    check(32'(flags), 32'h00000001);
    check({31'h0, irq}, 32'h00000001);
    apb(1'b1, amcid_pkg::IDX_IRQ_CLEAR, 32'h00000001);
    @(posedge pclk);
    check({31'h0, irq}, 32'h00000000);
    apb(1'b1, amcid_pkg::IDX_IRQ_ENABLE, 32'h0);
    pulse(1'b1);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, 32'h00000000);
    apb(1'b0, amcid_pkg::IDX_IRQ_STATUS, 32'h0);
    check(rd, 32'h00000001);
    // Random targets, both miss modes, a miss just before the target
    for (int i = 0; i < 6; i++) begin
      t = 2 + ($random(seed) & 3);
      mode = i & 1;
      apb(1'b1, amcid_pkg::IDX_TARGET, 32'(t));
      apb(1'b1, amcid_pkg::IDX_CONFIG, 32'(mode));
      apb(1'b0, amcid_pkg::IDX_TARGET, 32'h0);
      check(rd, 32'(t));
      k = flags;
      repeat (t - 1) pulse(1'b1);
      apb(1'b0, amcid_pkg::IDX_CONFIG, 32'h0);
      check(rd, 32'((t - 1) << amcid_pkg::CONFIG_COUNT_LSB) | 32'(mode));
      pulse(1'b0);
      apb(1'b0, amcid_pkg::IDX_CONFIG, 32'h0);
      check(rd, 32'(((mode == 1) ? t - 2 : 0) << amcid_pkg::CONFIG_COUNT_LSB) | 32'(mode));
      repeat ((mode == 1) ? 1 : t - 1) pulse(1'b1);
      repeat (2) @(posedge pclk);
      check(32'(flags), 32'(k));
      pulse(1'b1);
      repeat (2) @(posedge pclk);
      check(32'(flags), 32'(k + 1));
    end
    conclude();
  end
endmodule : adc_match_count_input_diag_test
